// >>> include/cis_cfg.svh
// constants for the instruction sequencer: opcodes, timing, widths
// assumes one core clock; no software-visible registers
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
`define CIS_OP_ADD_DIR 8'h5f
`define CIS_OP_ADD_IX 8'h47
`define CIS_OP_ADD_IY 8'h4f
`define CIS_OP_IMMEDIATE_SUM 8'h57
`define CIS_OP_AND_DIR 8'hbf
`define CIS_OP_AND_IX 8'ha7
`define CIS_OP_AND_IY 8'haf
`define CIS_OP_IMMEDIATE_MASK 8'hb7
`define CIS_OP_CLR_ACC 8'hdf
`define CIS_OP_CLR_RR 8'h0d
`define CIS_OP_COM 8'h2d
`define CIS_OP_RET 8'hcd
`define CIS_OP_INTERRUPT_EXIT 8'h4d
`define CIS_OP_STOP 8'h6d
`define CIS_OP_WAIT 8'hed
`define CIS_ACC_ADDR 8'hff
`define CIS_NIB_CALL 4'h1
`define CIS_NIB_JP 4'h9
`define CIS_LOW_BRANCH_IF_NONZERO 3'h0
`define CIS_LOW_JRZ 3'h4
`define CIS_LOW_BRANCH_IF_NO_CARRY 3'h2
`define CIS_LOW_JRC 3'h6
`define CIS_LOW_BT 4'h3
`define CIS_STACK_DEPTH 6
`define CIS_OSC_EXTRA 16
`define CIS_OSC_START_CYC 1024
`define CIS_ROM_BASE 12'h000
`endif

// >>> include/cis_pkg.sv
// types of the instruction sequencer
// constants live in cis_cfg.svh
package cis_pkg;
  typedef enum logic [3:0] {
    CIS_FETCH, CIS_C2, CIS_C3, CIS_C4, CIS_C5, CIS_INT, CIS_OSC, CIS_HALT
  } cis_state_e;
  typedef logic [11:0] cis_addr_t;
endpackage

// >>> logic/cis_stack.sv
// six-level return stack, shared by calls and interrupts
// assumes push and pop never in the same cycle
`timescale 1ns/10ps
module cis_stack #(
  parameter int DEPTH = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] push_addr,
  // top of stack
  output logic [11:0] top_addr
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [11:0] mem_r [DEPTH];
  logic [CW-1:0] fill_r;
  // shift register with a fill count; a push onto a full stack is dropped,
  // so the newest return is lost and the earliest ones survive
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= 12'h000;
      fill_r <= '0;
    end else if (push) begin
      if (fill_r != CW'(DEPTH)) begin
        mem_r[0] <= push_addr;
        for (int i = 1; i < DEPTH; i++) mem_r[i] <= mem_r[i-1];
        fill_r <= fill_r + 1'b1;
      end
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) mem_r[i] <= mem_r[i+1];
      mem_r[DEPTH-1] <= mem_r[DEPTH-1]; // empty pops repeat oldest
      if (fill_r != '0) fill_r <= fill_r - 1'b1;
    end
  end
  assign top_addr = mem_r[0];
endmodule

// >>> logic/cis_alu.sv
// accumulator alu: add, and, complement, clear with flag results
// combinational; the sequencer registers its outputs
`timescale 1ns/10ps
module cis_alu (
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] src,
  input wire logic carry_in,
  input wire logic zero_in,
  // operation select
  input wire logic [1:0] op,
  // results
  output logic [7:0] result,
  output logic carry_out,
  output logic zero_out
);
  logic [8:0] sum;
  assign sum = {1'b0, acc} + {1'b0, src};
  // op 0 add, 1 and, 2 complement, 3 clear
  always_comb begin
    result = acc;
    carry_out = carry_in;
    zero_out = zero_in;
    case (op)
      2'h0: begin
        result = sum[7:0];
        carry_out = sum[8];
        zero_out = (sum[7:0] == 8'h00);
      end
      2'h1: begin
        result = acc & src;
        zero_out = ((acc & src) == 8'h00);
      end
      2'h2: begin
        result = ~acc;
        carry_out = acc[7];
        zero_out = (acc == 8'hff);
      end
      default: begin
        result = 8'h00;
        carry_out = 1'b1;
        zero_out = 1'b1;
      end
    endcase
  end
endmodule

// >>> logic/cis_core.sv
// instruction sequencer: decode and cycle sequencing of control flow
// and accumulator arithmetic for an 8-bit core
// assumes program rom and data space answer combinationally in the cycle
`timescale 1ns/10ps
`include "cis_cfg.svh"
module cis_core
  import cis_pkg::*;
#(
  parameter int OSC_START_CYC = `CIS_OSC_START_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // program memory
  output logic [11:0] prog_addr,
  input wire logic [7:0] prog_data,
  // data space
  output logic [7:0] ds_addr,
  output logic ds_rd,
  output logic ds_wr,
  output logic [7:0] ds_wdata,
  input wire logic [7:0] ds_rdata,
  input wire logic ds_rom_hit,
  output logic rom_data_cycle,
  // interrupt
  input wire logic irq_req,
  input wire logic [11:0] irq_vector,
  // status
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic zero_out,
  output logic int_flags_active,
  output logic osc_stopped,
  output logic core_waiting
);
  localparam logic [4:0] OSC_WAIT = 5'(`CIS_OSC_EXTRA);

  typedef struct packed {
    cis_state_e st;
    logic [11:0] pc;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] disp;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic c_n, z_n, c_i, z_i;
    logic in_int;
    logic stopped;
    logic waiting;
    logic [15:0] cnt;
    logic irq_s1, irq_s2;
  } cis_core_s;

  cis_core_s q_r, q_nxt;
  logic push, pop;
  logic [11:0] push_addr, top_addr;
  logic [1:0] alu_op;
  logic [7:0] alu_src, alu_res;
  logic alu_c, alu_z;
  logic cur_c, cur_z;
  logic [11:0] rel_tgt;

  // return stack
  cis_stack #(.DEPTH(`CIS_STACK_DEPTH)) u_stack (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(push),
    .pop(pop),
    .push_addr(push_addr),
    .top_addr(top_addr)
  );

  // flag set in use depends on interrupt context
  assign cur_c = q_r.in_int ? q_r.c_i : q_r.c_n;
  assign cur_z = q_r.in_int ? q_r.z_i : q_r.z_n;

  cis_alu u_alu (
    .acc(q_r.acc),
    .src(alu_src),
    .carry_in(cur_c),
    .zero_in(cur_z),
    .op(alu_op),
    .result(alu_res),
    .carry_out(alu_c),
    .zero_out(alu_z)
  );

  // relative target: displacement in opcode bits 7:3, -15..+16
  assign rel_tgt = q_r.pc + {7'h00, q_r.op[7:3]} - 12'h00f;

  // sequencing
  always_comb begin
    logic take;
    logic [11:0] ea;
    take = 1'b0;
    ea = 12'h000;
    q_nxt = q_r;
    push = 1'b0;
    pop = 1'b0;
    push_addr = q_r.pc;
    alu_op = 2'h0;
    alu_src = q_r.opnd;
    prog_addr = q_r.pc;
    ds_addr = 8'h00;
    ds_rd = 1'b0;
    ds_wr = 1'b0;
    ds_wdata = alu_res;
    rom_data_cycle = 1'b0;
    // pin input synchroniser
    q_nxt.irq_s1 = irq_req;
    q_nxt.irq_s2 = q_r.irq_s1;
    case (q_r.st)
      CIS_FETCH: begin
        if (q_r.irq_s2 && !q_r.in_int) begin
          q_nxt.st = CIS_INT;
        end else begin
          q_nxt.op = prog_data;
          q_nxt.pc = q_r.pc + 12'h001;
          q_nxt.st = CIS_C2;
        end
      end
      CIS_INT: begin
        push = 1'b1;
        q_nxt.pc = irq_vector;
        q_nxt.in_int = 1'b1;
        q_nxt.st = CIS_FETCH;
      end
      CIS_HALT: begin
        // stopped oscillator or wait idle until interrupt
        if (q_r.irq_s2) begin
          q_nxt.waiting = 1'b0;
          q_nxt.cnt = 16'h0000;
          q_nxt.st = q_r.stopped ? CIS_OSC : CIS_INT;
        end
      end
      CIS_OSC: begin
        q_nxt.cnt = q_r.cnt + 16'h0001;
        if (q_r.cnt >= 16'(OSC_START_CYC) + 16'(OSC_WAIT) - 16'h0001) begin
          q_nxt.stopped = 1'b0;
          q_nxt.st = CIS_INT;
        end
      end
      CIS_C2: begin
        q_nxt.st = CIS_C3;
        if (q_r.op[2:0] == `CIS_LOW_JRZ || q_r.op[2:0] == `CIS_LOW_BRANCH_IF_NONZERO ||
            q_r.op[2:0] == `CIS_LOW_JRC || q_r.op[2:0] == `CIS_LOW_BRANCH_IF_NO_CARRY) begin
          case (q_r.op[2:0])
            `CIS_LOW_JRZ: take = cur_z;
            `CIS_LOW_BRANCH_IF_NONZERO: take = !cur_z;
            `CIS_LOW_JRC: take = cur_c;
            default: take = !cur_c;
          endcase
          if (take) q_nxt.pc = rel_tgt;
          q_nxt.st = CIS_FETCH;
        end else if (q_r.op == `CIS_OP_RET || q_r.op == `CIS_OP_INTERRUPT_EXIT) begin
          prog_addr = top_addr;
          pop = 1'b1;
          q_nxt.pc = top_addr;
          if (q_r.op == `CIS_OP_INTERRUPT_EXIT) q_nxt.in_int = 1'b0;
          q_nxt.st = CIS_FETCH;
        end else if (q_r.op == `CIS_OP_STOP || q_r.op == `CIS_OP_WAIT) begin
          q_nxt.stopped = (q_r.op == `CIS_OP_STOP);
          q_nxt.waiting = (q_r.op == `CIS_OP_WAIT);
          q_nxt.st = CIS_HALT;
        end else if (q_r.op[3:0] == `CIS_LOW_BT) begin
          q_nxt.b2 = prog_data; // operand address
          q_nxt.pc = q_r.pc + 12'h001;
        end else if (q_r.op == `CIS_OP_COM) begin
          ds_addr = `CIS_ACC_ADDR;
        end else begin
          // second byte: address, immediate or jump low byte
          q_nxt.b2 = prog_data;
          if (q_r.op != `CIS_OP_ADD_IX && q_r.op != `CIS_OP_ADD_IY &&
              q_r.op != `CIS_OP_AND_IX && q_r.op != `CIS_OP_AND_IY)
            q_nxt.pc = q_r.pc + 12'h001;
          if (q_r.op[3:0] == `CIS_NIB_CALL) q_nxt.cnt = 16'h0000;
        end
      end
      CIS_C3: begin
        q_nxt.st = CIS_C4;
        if (q_r.op[3:0] == `CIS_LOW_BT) begin
          ds_addr = q_r.b2;
          ds_rd = 1'b1;
          rom_data_cycle = ds_rom_hit;
          q_nxt.opnd = ds_rdata;
        end else if (q_r.op[3:0] == `CIS_NIB_CALL) begin
          push = 1'b1;
        end else if (q_r.op == `CIS_OP_COM) begin
          q_nxt.opnd = q_r.acc;
        end else if (q_r.op == `CIS_OP_IMMEDIATE_SUM || q_r.op == `CIS_OP_IMMEDIATE_MASK) begin
          q_nxt.opnd = q_r.b2;
        end else if (q_r.op == `CIS_OP_ADD_IX || q_r.op == `CIS_OP_AND_IX ||
                     q_r.op == `CIS_OP_ADD_IY || q_r.op == `CIS_OP_AND_IY) begin
          ds_addr = q_r.op[3] ? 8'h81 : 8'h80; // pointer register
          ds_rd = 1'b1;
          q_nxt.b2 = ds_rdata;
        end else if (q_r.op[3:0] != `CIS_NIB_JP) begin
          ds_addr = q_r.b2; // idle else direct read
          ds_rd = 1'b1;
          q_nxt.opnd = ds_rdata;
        end
      end
      CIS_C4: begin
        q_nxt.st = CIS_FETCH;
        prog_addr = q_r.pc;
        if (q_r.op[3:0] == `CIS_LOW_BT) begin
          q_nxt.disp = prog_data; // branch value, operand address kept
          q_nxt.pc = q_r.pc + 12'h001;
          q_nxt.st = CIS_C5;
        end else if (q_r.op[3:0] == `CIS_NIB_CALL || q_r.op[3:0] == `CIS_NIB_JP) begin
          q_nxt.pc = {q_r.op[7:4], q_r.b2};
        end else begin
          case (q_r.op)
            `CIS_OP_COM: alu_op = 2'h2;
            `CIS_OP_CLR_ACC: alu_op = (q_r.b2 == `CIS_ACC_ADDR) ? 2'h3 : 2'h0;
            `CIS_OP_AND_DIR, `CIS_OP_AND_IX, `CIS_OP_AND_IY, `CIS_OP_IMMEDIATE_MASK: alu_op = 2'h1;
            default: alu_op = 2'h0;
          endcase
          if (q_r.op == `CIS_OP_ADD_IX || q_r.op == `CIS_OP_ADD_IY ||
              q_r.op == `CIS_OP_AND_IX || q_r.op == `CIS_OP_AND_IY) begin
            ds_addr = q_r.b2;
            ds_rd = 1'b1;
            rom_data_cycle = ds_rom_hit;
            alu_src = ds_rdata;
          end
          if (q_r.op == `CIS_OP_CLR_RR) begin
            ds_addr = q_r.b2; // flags kept
            ds_wr = 1'b1;
            ds_wdata = 8'h00;
            q_nxt.pc = q_r.pc + 12'h001;
          end else if (q_r.op == `CIS_OP_COM || q_r.op == `CIS_OP_CLR_ACC ||
                       q_r.op == `CIS_OP_ADD_DIR || q_r.op == `CIS_OP_ADD_IX ||
                       q_r.op == `CIS_OP_ADD_IY || q_r.op == `CIS_OP_IMMEDIATE_SUM ||
                       q_r.op == `CIS_OP_AND_DIR || q_r.op == `CIS_OP_AND_IX ||
                       q_r.op == `CIS_OP_AND_IY || q_r.op == `CIS_OP_IMMEDIATE_MASK) begin
            q_nxt.acc = alu_res;
            if (q_r.in_int) begin
              q_nxt.c_i = alu_c;
              q_nxt.z_i = alu_z;
            end else begin
              q_nxt.c_n = alu_c;
              q_nxt.z_n = alu_z;
            end
          end
        end
      end
      CIS_C5: begin
        ds_addr = q_r.b2;
        rom_data_cycle = ds_rom_hit;
        ea = q_r.pc + {{4{q_r.disp[7]}}, q_r.disp};
        if (q_r.opnd[q_r.op[7:5]] == q_r.op[4]) q_nxt.pc = ea;
        q_nxt.st = CIS_FETCH;
      end
      default: q_nxt.st = CIS_FETCH;
    endcase
  end

  // single register for all core state except the return stack
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '{st: CIS_FETCH, pc: `CIS_ROM_BASE, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign acc_out = q_r.acc;
  assign carry_out = cur_c;
  assign zero_out = cur_z;
  assign int_flags_active = q_r.in_int;
  assign osc_stopped = q_r.stopped;
  assign core_waiting = q_r.waiting;
endmodule

// >>> tb/cis_mem_model.sv
// program rom and data space model for the instruction sequencer
// assumes the core samples read data in the same cycle it asks
`timescale 1ns/10ps
`include "cis_cfg.svh"
module cis_mem_model (
  // clock
  input wire logic ref_clk,
  // program side
  input wire logic [11:0] prog_addr,
  output logic [7:0] prog_data,
  // data side
  input wire logic [7:0] ds_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  input wire logic [7:0] acc,
  output logic [7:0] ds_rdata,
  output logic ds_rom_hit
);
  logic [7:0] rom [4096];
  logic [7:0] ram [256];
  logic [7:0] last = 8'h00;
  // rom answers in the same cycle
  assign prog_data = rom[prog_addr];
  // upper half of the low half (ds_addr[7:6] == 01) flags rom data space; reads still return ram
  assign ds_rom_hit = ds_addr[7:6] == 2'b01;
  // idle bus shows the inverse of the last byte, never a stale copy
  assign ds_rdata = !ds_rd ? ~last : (ds_addr == `CIS_ACC_ADDR) ? acc : ram[ds_addr];
  // writes land at the edge
  always @(posedge ref_clk) begin
    if (ds_rd) last <= ds_rdata;
    if (ds_wr) ram[ds_addr] <= ds_wdata;
  end
endmodule

// >>> tb/cis_core_sva.sv
// port assertions for the sequencer: halt, interrupt entry, flags, strobes
// single clock domain; bound to every cis_core
`timescale 1ns/10ps
module cis_core_sva #(
  parameter int OSC_START_CYC = 1024
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // memory side
  input wire logic [11:0] prog_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic ds_rom_hit,
  input wire logic rom_data_cycle,
  // interrupt and status
  input wire logic irq_req,
  input wire logic [11:0] irq_vector,
  input wire logic [7:0] acc_out,
  input wire logic zero_out,
  input wire logic int_flags_active,
  input wire logic osc_stopped,
  input wire logic core_waiting
);
  int unsigned wake_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // cycles since a wake request reached a stopped core
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt <= 0;
    end else if (int_flags_active) begin
      wake_cnt <= 0;
    end else if (wake_cnt != 0 || (osc_stopped && irq_req)) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  sequence s_entry;
    $rose(int_flags_active);
  endsequence
  sequence s_quiet;
    !irq_req [*3];
  endsequence
  chk_int_vector: assert property (s_entry |-> ##[0:2] prog_addr == irq_vector)
    else $error("interrupt entry missed the vector");
  chk_stop_wake: assert property (
    s_entry ##0 (wake_cnt != 0) |-> wake_cnt >= OSC_START_CYC + 16)
    else $error("wake from stop too early");
  chk_halt_hold: assert property (s_quiet ##0 osc_stopped |=> osc_stopped)
    else $error("stopped core woke without request");
  chk_wait_hold: assert property (s_quiet ##0 core_waiting |=> core_waiting)
    else $error("waiting core woke without request");
  chk_mode_excl: assert property (!(osc_stopped && core_waiting))
    else $error("stop and wait both active");
  chk_zero_track: assert property ($changed(acc_out) |-> zero_out == (acc_out == 8'h00))
    else $error("zero flag disagrees with accumulator");
  chk_rom_qual: assert property (rom_data_cycle |-> ds_rom_hit)
    else $error("rom data cycle outside rom space");
  chk_rom_pulse: assert property (rom_data_cycle |=> !rom_data_cycle)
    else $error("rom data cycle longer than one cycle");
  chk_wr_pulse: assert property (ds_wr |-> !ds_rd ##1 !ds_wr)
    else $error("data write not a lone pulse");
endmodule
bind cis_core cis_core_sva #(.OSC_START_CYC(OSC_START_CYC)) cis_core_sva_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .prog_addr(prog_addr), .ds_rd(ds_rd),
  .ds_wr(ds_wr), .ds_rom_hit(ds_rom_hit), .rom_data_cycle(rom_data_cycle),
  .irq_req(irq_req), .irq_vector(irq_vector), .acc_out(acc_out), .zero_out(zero_out),
  .int_flags_active(int_flags_active), .osc_stopped(osc_stopped),
  .core_waiting(core_waiting));

// >>> tb/cpu_instruction_sequencer_bench.sv
// bench for the sequencer: alu ops, jumps, branches, stop and wait
// assumes the memory model answers in the same cycle
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module cpu_instruction_sequencer_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic irq_req = 1'b0;
  logic [11:0] irq_vector = 12'h200;
  logic [11:0] prog_addr;
  logic [7:0] prog_data, ds_addr, ds_wdata, ds_rdata, acc_out;
  logic ds_rd, ds_wr, ds_rom_hit, rom_data_cycle, carry_out, zero_out;
  logic int_flags_active, osc_stopped, core_waiting;
  int n_errors = 0;
  int compares = 0;
  localparam int OSC = 4;
  cis_core #(.OSC_START_CYC(OSC)) cis_core_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .prog_addr(prog_addr), .prog_data(prog_data), .ds_addr(ds_addr), .ds_rd(ds_rd),
    .ds_wr(ds_wr), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .ds_rom_hit(ds_rom_hit),
    .rom_data_cycle(rom_data_cycle), .irq_req(irq_req), .irq_vector(irq_vector),
    .acc_out(acc_out), .carry_out(carry_out), .zero_out(zero_out),
    .int_flags_active(int_flags_active), .osc_stopped(osc_stopped),
    .core_waiting(core_waiting));
  cis_mem_model cis_mem_model_i (.ref_clk(ref_clk), .prog_addr(prog_addr),
    .prog_data(prog_data), .ds_addr(ds_addr), .ds_rd(ds_rd), .ds_wr(ds_wr),
    .ds_wdata(ds_wdata), .acc(acc_out), .ds_rdata(ds_rdata), .ds_rom_hit(ds_rom_hit));
  // 100 ns clock
  initial forever #50 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // reset held five cycles; pc restarts at zero
  task automatic boot();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask
  task automatic put(input logic [11:0] a, input logic [7:0] b);
    cis_mem_model_i.rom[a] = b;
  endtask
  // chained alu ops, each checked after its four cycles; ends in a park loop
  task automatic t_alu();
    logic [7:0] p[20] = '{8'h57, 8'hff, 8'h57, 8'h02, 8'hb7, 8'h0e, 8'h2d, 8'hbf,
      8'h22, 8'ha7, 8'hdf, 8'hff, 8'h0d, 8'h22, 8'h00, 8'h47, 8'h4f, 8'haf, 8'h5f, 8'h45};
    logic [9:0] e[12] = '{{8'hff, 2'b00}, {8'h01, 2'b10}, {8'h00, 2'b11},
      {8'hff, 2'b00}, {8'h33, 2'b00}, {8'h33, 2'b00}, {8'h00, 2'b11}, {8'h00, 2'b11},
      {8'h00, 2'b01}, {8'h05, 2'b00}, {8'h05, 2'b00}, {8'h0a, 2'b00}};
    foreach (p[i]) put(12'(i), p[i]);
    put(12'h014, 8'h09);
    put(12'h015, 8'h14);
    cis_mem_model_i.ram[8'h22] = 8'h33;
    cis_mem_model_i.ram[8'h80] = 8'h22;
    cis_mem_model_i.ram[8'h81] = 8'h23;
    cis_mem_model_i.ram[8'h23] = 8'h05;
    cis_mem_model_i.ram[8'h45] = 8'h05;
    boot();
    foreach (e[i]) begin
      cyc(4);
      `CHK({acc_out, carry_out, zero_out}, e[i])
    end
    `CHK(cis_mem_model_i.ram[8'h22], 8'h00)
  endtask
  // jump, call and return with exact cycle counts
  task automatic t_flow();
    put(12'h000, 8'h59);
    put(12'h001, 8'hcd);
    put(12'h5cd, 8'h81);
    put(12'h5ce, 8'h00);
    put(12'h800, 8'hcd);
    boot();
    cyc(4);
    `CHK(prog_addr, 12'h5cd)
    cyc(4);
    `CHK(prog_addr, 12'h800)
    cyc(2);
    `CHK(prog_addr, 12'h5cf)
    `CHK({carry_out, zero_out}, 2'b00)
  endtask
  // flags clear after reset: two branches fall through, the third is taken
  task automatic t_branch();
    put(12'h000, 8'ha6);
    put(12'h001, 8'ha4);
    put(12'h002, 8'ha2);
    boot();
    cyc(2);
    `CHK(prog_addr, 12'h001)
    cyc(2);
    `CHK(prog_addr, 12'h002)
    cyc(2);
    `CHK(prog_addr, 12'h008)
  endtask
  // bit-test branches: set bit taken, then reset bit in rom data space
  task automatic t_bit();
    put(12'h000, 8'h13);
    put(12'h001, 8'h45);
    put(12'h002, 8'h04);
    put(12'h007, 8'h03);
    put(12'h008, 8'h50);
    put(12'h009, 8'h02);
    cis_mem_model_i.ram[8'h45] = 8'h05;
    cis_mem_model_i.ram[8'h50] = 8'h00;
    boot();
    cyc(5);
    `CHK(prog_addr, 12'h007)
    cyc(2);
    `CHK(rom_data_cycle, 1'b1)
    cyc(3);
    `CHK(prog_addr, 12'h00c)
  endtask
  // halt or idle, wake by interrupt, leave by interrupt exit
  task automatic t_halt(input logic [7:0] op);
    int k;
    put(12'h000, op);
    put(12'h001, 8'h09);
    put(12'h002, 8'h01);
    put(12'h200, 8'h4d);
    boot();
    cyc(2);
    `CHK({osc_stopped, core_waiting}, (op == 8'h6d) ? 2'b10 : 2'b01)
    @(posedge ref_clk);
    irq_req <= 1'b1;
    k = 0;
    while (int_flags_active !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    @(posedge ref_clk);
    irq_req <= 1'b0;
    if (op == 8'h6d) `CHK(k >= OSC + 16, 1'b1)
    `CHK(int_flags_active, 1'b1)
    k = 0;
    while (int_flags_active !== 1'b0 && k < 8) begin
      cyc(1);
      k++;
    end
    `CHK({int_flags_active, osc_stopped, core_waiting}, 3'b000)
  endtask
  initial begin
    t_alu();
    t_flow();
    t_branch();
    t_bit();
    t_halt(8'h6d);
    t_halt(8'hed);
    test_done();
  end
  // watchdog well past the expected run
  initial begin
    #(100 * 3000);
    n_errors++;
    test_done();
  end
  task automatic test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
